// >>> hw/xpc_dev.sv
// Crosspoint switch device: link slave, command decode, switch array
//
// Added by the designer: register access over Avalon-MM and the address map.
module xpc_dev (
    input wire logic mclk,
    input wire logic rst,
    xpc_if.dev link,
    input wire logic address_strap_bit0,
    input wire logic address_strap_bit1,
    input wire logic address_strap_bit2,
    output logic [95:0] switch_closed
);
    typedef enum logic [1:0] {D_IDLE, D_RECV, D_ACK, D_SEND} xpc_dst_e;

    // ------------------------------------------------------------
    // Pin synchronisers and link event detection
    // ------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    logic scl_s, sda_s, rst_n_s, link_rst;
    logic [2:0] strap_s;
    logic scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start, stop;

    assign pin_raw = {address_strap_bit2, address_strap_bit1,
                      address_strap_bit0, link.rst_n, link.sda, link.scl};

    xpc_sync #(.W(6)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(pin_raw),
        .q(pin_s)
    );

    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];
    assign rst_n_s = pin_s[2];
    assign strap_s = pin_s[5:3];
    assign link_rst = ~rst_n_s; // R12

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_d_r <= 1'b0;
            sda_d_r <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Shifting and sampling happen only on link clock edges
    assign scl_rise = scl_s & ~scl_d_r; // R02
    assign scl_fall = ~scl_s & scl_d_r;
    assign start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ------------------------------------------------------------
    // Serial command word
    // ------------------------------------------------------------
    xpc_dst_e state_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [23:0] serial_command_word;
    logic [23:0] word_nxt;
    logic rw_r, oe_r;
    logic [15:0] tx_r;
    logic [15:0] tx_load;
    logic [3:0] rbrow_r;
    logic addr_ok, byte_end, cmd_go;

    assign word_nxt = {serial_command_word[22:0], sda_s}; // R02
    assign addr_ok = word_nxt[7:4] == xpc_pkg::ADDR_HI
        && word_nxt[3:1] == strap_s; // R03
    assign byte_end = state_r == D_RECV && scl_rise
        && bit_r == xpc_pkg::BYTE_LAST_BIT;
    // Word is acted on when its last bit arrives, before the ack slot
    assign cmd_go = byte_end && byte_r == xpc_pkg::LAST_BYTE
        && ~rw_r && ~start && ~stop && ~link_rst; // R01 R04

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_command_word <= '0;
        end else if (link_rst) begin
            serial_command_word <= '0; // R12
        end else if (state_r == D_RECV && scl_rise) begin
            serial_command_word <= word_nxt; // R02
        end
    end

    // ------------------------------------------------------------
    // Link protocol
    // ------------------------------------------------------------
    // Status goes out column 7 first, after an all-zero byte
    assign tx_load = {8'h00, switch_closed[{rbrow_r, 3'h0}+:8]}; // R15

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= D_IDLE;
            bit_r <= '0;
            byte_r <= '0;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            tx_r <= '0;
        end else if (link_rst) begin
            state_r <= D_IDLE; // R12
            bit_r <= '0;
            byte_r <= '0;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            tx_r <= '0;
        end else if (start) begin
            state_r <= D_RECV;
            bit_r <= '0;
            byte_r <= '0;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (stop) begin
            state_r <= D_IDLE;
            oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                D_IDLE: begin
                end
                D_RECV: begin
                    if (scl_rise) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == xpc_pkg::BYTE_LAST_BIT) begin
                            if (byte_r == 2'h0) begin
                                rw_r <= word_nxt[0]; // R04
                                state_r <= addr_ok ? D_ACK : D_IDLE; // R03
                            end else begin
                                state_r <= D_ACK;
                            end
                        end
                    end
                end
                D_ACK: begin
                    if (scl_fall) begin
                        bit_r <= '0;
                        if (~oe_r) begin
                            oe_r <= 1'b1;
                        end else if (rw_r) begin
                            state_r <= D_SEND;
                            byte_r <= '0;
                            oe_r <= ~tx_load[15]; // R15
                            tx_r <= {tx_load[14:0], 1'b0};
                        end else if (byte_r == xpc_pkg::LAST_BYTE) begin
                            // Bytes past the third get no ack
                            state_r <= D_IDLE; // R01
                            oe_r <= 1'b0;
                        end else begin
                            state_r <= D_RECV;
                            byte_r <= byte_r + 2'h1;
                            oe_r <= 1'b0;
                        end
                    end
                end
                D_SEND: begin
                    if (scl_rise) begin
                        if (bit_r == xpc_pkg::ACK_BIT) begin
                            bit_r <= '0;
                            if (~sda_s && byte_r == 2'h0) begin
                                byte_r <= 2'h1;
                            end else begin
                                state_r <= D_IDLE; // R15
                            end
                        end else begin
                            bit_r <= bit_r + 4'h1;
                        end
                    end else if (scl_fall) begin
                        if (bit_r == xpc_pkg::ACK_BIT) begin
                            oe_r <= 1'b0;
                        end else begin
                            oe_r <= ~tx_r[15]; // R15
                            tx_r <= {tx_r[14:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    assign link.s_sda_o = 1'b0;
    assign link.s_sda_oe = oe_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [2:0] col_idx;
    logic [3:0] row_idx;
    logic row_ok, sw_on, load_switch_update;

    // Bits 7 to 1 are never looked at
    assign col_idx = word_nxt[xpc_pkg::CW_COL_LO+:3]; // R07
    assign sw_on = word_nxt[xpc_pkg::CW_DATA]; // R05
    assign load_switch_update = word_nxt[xpc_pkg::CW_LOAD]; // R08 R09 R11
    // Row codes with low bits 110/111 are reserved and write nothing
    assign row_ok = word_nxt[xpc_pkg::CW_ROW_LO+:3] <= xpc_pkg::ROW_MAX; // R06
    assign row_idx = word_nxt[xpc_pkg::CW_ROW_LO+3]
        ? xpc_pkg::ROW_HALF + {1'b0, word_nxt[xpc_pkg::CW_ROW_LO+:3]}
        : {1'b0, word_nxt[xpc_pkg::CW_ROW_LO+:3]}; // R06

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rbrow_r <= '0;
        end else if (link_rst) begin
            rbrow_r <= '0; // R12
        end else if (cmd_go && row_ok) begin
            rbrow_r <= row_idx; // R15
        end
    end

    // ------------------------------------------------------------
    // Input latch and switch array, one row per generate entry
    // ------------------------------------------------------------
    for (genvar r = 0; r < xpc_pkg::ROWS; r++) begin : g_row
        logic [7:0] latch_r;
        logic [7:0] sw_r;
        logic [7:0] latch_nxt;

        always_comb begin
            latch_nxt = latch_r;
            if (cmd_go && row_ok && row_idx == 4'(r)) begin
                latch_nxt[col_idx] = sw_on; // R14
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                latch_r <= '0; // R12
                sw_r <= '0;
            end else if (link_rst) begin
                latch_r <= '0; // R12
                sw_r <= '0;
            end else begin
                latch_r <= latch_nxt; // R09
                // Every row loads at once, so earlier latched words land too
                if (cmd_go && row_ok && load_switch_update) begin
                    sw_r <= latch_nxt; // R08 R13
                end
            end
        end

        assign switch_closed[r*8+:8] = sw_r;
    end
endmodule

// >>> hw/xpc_host.sv
// Link controller: Avalon-MM registers driving the two-wire link
module xpc_host (
    input wire logic mclk,
    input wire logic rst,
    xpc_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} xpc_hst_e;

    xpc_hst_e state_r;
    logic [3:0] qcnt_r;
    logic [1:0] phase_r;
    logic [3:0] bit_r;
    logic [1:0] slot_r;
    logic [23:0] tx_r;
    logic [15:0] rx_r;
    logic rd_r, busy_r, nack_r, badrow_r, run_r, rd_done_r;
    logic scl_r, drv_r, scl_nxt, drv_nxt;
    logic sda_s, tick, sends, reserved, cmd_take;

    xpc_sync #(.W(1)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(link.sda),
        .q(sda_s)
    );

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    // Writes stall while a frame runs, so reset cannot drop mid-frame
    assign avs_waitrequest = (avs_read & ~rd_done_r) | (avs_write & busy_r);
    assign reserved = avs_writedata[xpc_pkg::CW_ROW_LO+:3] > xpc_pkg::ROW_MAX
        & ~avs_writedata[xpc_pkg::CMD_RD]; // R06
    assign cmd_take = avs_write & ~busy_r & run_r
        & avs_address == xpc_pkg::REG_CMD & ~reserved;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_done_r <= 1'b0;
            avs_readdata <= '0;
        end else begin
            rd_done_r <= avs_read & ~rd_done_r;
            if (avs_read & ~rd_done_r) begin
                unique case (avs_address)
                    xpc_pkg::REG_CTRL: avs_readdata <= {31'h0, run_r};
                    xpc_pkg::REG_STAT:
                        avs_readdata <= {29'h0, badrow_r, nack_r, busy_r};
                    xpc_pkg::REG_RDATA: avs_readdata <= {16'h0, rx_r};
                    default: avs_readdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_r <= xpc_pkg::CTRL_RUN_RST;
        end else if (avs_write & ~busy_r
                     & avs_address == xpc_pkg::REG_CTRL) begin
            run_r <= avs_writedata[0]; // R10
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            badrow_r <= 1'b0;
        end else if (avs_write & ~busy_r
                     & avs_address == xpc_pkg::REG_CMD) begin
            badrow_r <= reserved; // R06
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    assign tick = qcnt_r == xpc_pkg::Q_CYC - 4'h1;
    assign sends = ~rd_r | slot_r == 2'h0;

    always_comb begin
        scl_nxt = 1'b1;
        drv_nxt = 1'b0;
        unique case (state_r)
            H_IDLE: begin
            end
            H_START: begin
                scl_nxt = phase_r != 2'h3;
                drv_nxt = phase_r != 2'h0;
            end
            H_BIT: begin
                scl_nxt = phase_r[1];
                if (bit_r == xpc_pkg::ACK_BIT) begin
                    drv_nxt = ~sends & slot_r == 2'h1;
                end else begin
                    drv_nxt = sends & ~tx_r[23];
                end
            end
            H_STOP: begin
                scl_nxt = phase_r != 2'h0;
                drv_nxt = ~phase_r[1];
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_r <= 1'b1;
            drv_r <= 1'b0;
        end else begin
            scl_r <= scl_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign link.scl = scl_r;
    assign link.m_sda_o = 1'b0;
    assign link.m_sda_oe = drv_r;
    assign link.rst_n = run_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= H_IDLE;
            qcnt_r <= '0;
            phase_r <= '0;
            bit_r <= '0;
            slot_r <= '0;
            tx_r <= '0;
            rx_r <= '0;
            rd_r <= 1'b0;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (state_r == H_IDLE) begin
            qcnt_r <= '0;
            phase_r <= '0;
            if (cmd_take) begin
                state_r <= H_START;
                busy_r <= 1'b1;
                nack_r <= 1'b0;
                bit_r <= '0;
                slot_r <= '0;
                rd_r <= avs_writedata[xpc_pkg::CMD_RD]; // R04
                tx_r <= {xpc_pkg::ADDR_HI,
                         avs_writedata[xpc_pkg::CMD_SA_LO+:3],
                         avs_writedata[xpc_pkg::CMD_RD],
                         avs_writedata[15:0]}; // R01 R13
            end
        end else begin
            qcnt_r <= tick ? 4'h0 : qcnt_r + 4'h1;
            if (tick) begin
                phase_r <= phase_r + 2'h1;
            end
            if (tick && phase_r == 2'h3) begin
                unique case (state_r)
                    H_START: state_r <= H_BIT;
                    H_STOP: begin
                        state_r <= H_IDLE;
                        busy_r <= 1'b0;
                    end
                    default: begin
                        if (bit_r == xpc_pkg::ACK_BIT) begin
                            bit_r <= '0;
                            if (sends && sda_s) begin
                                nack_r <= 1'b1;
                                state_r <= H_STOP;
                            end else if (slot_r == xpc_pkg::LAST_BYTE) begin
                                state_r <= H_STOP;
                            end else begin
                                slot_r <= slot_r + 2'h1;
                            end
                        end else begin
                            bit_r <= bit_r + 4'h1;
                            if (sends) begin
                                tx_r <= {tx_r[22:0], 1'b0};
                            end else begin
                                rx_r <= {rx_r[14:0], sda_s}; // R15
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

// >>> hw/xpc_if.sv
// Two-wire link between crosspoint controller and switch device
interface xpc_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;
    logic rst_n;

    // Open-drain wire: any enabled low driver pulls the line low
    assign sda = (~m_sda_oe | m_sda_o) & (~s_sda_oe | s_sda_o);

    modport host (
        output scl,
        output m_sda_o,
        output m_sda_oe,
        output rst_n,
        input sda
    );
    modport dev (
        input scl,
        input sda,
        input rst_n,
        output s_sda_o,
        output s_sda_oe
    );
endinterface

// >>> hw/xpc_pkg.sv
// Constants for the crosspoint switch command link
// ----------------------------------------------------------------
// Behaviour
// R01: Write is address byte plus two command bytes
// R02: Device shifts bits on link clock only
// R03: Answer only address 1110 plus strap pins
// R04: Bit 16 high reads, low writes
// R05: Bit 15 closes switch, low opens
// R06: Row codes 0-5, 8-13; others reserved
// R07: Bits 10-8 select column in binary
// R08: Load bit high applies word to array
// R09: Load bit low only latches the setting
// R10: Controller keeps reset pin high during writes
// R11: Bits 7 to 1 are ignored
// R12: Reset low opens all switches, clears state
// R13: Last word loads all latched settings together
// R14: Write changes only the addressed switch
// R15: Readback returns zero byte, then row status
// ----------------------------------------------------------------
package xpc_pkg;
    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int ROWS = 12;
    localparam int COLS = 8;
    localparam logic [3:0] ADDR_HI = 4'he;
    localparam int CW_RW = 16;
    localparam int CW_DATA = 15;
    localparam int CW_ROW_LO = 11;
    localparam int CW_COL_LO = 8;
    localparam int CW_LOAD = 0;
    localparam logic [2:0] ROW_MAX = 3'h5;
    localparam logic [3:0] ROW_HALF = 4'h6;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_NS = 50;
    localparam int SCL_QUARTER_NS = 250;
    localparam int Q_CYC_I = (SCL_QUARTER_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [3:0] Q_CYC = 4'(Q_CYC_I);
    // ------------------------------------------------------------
    // Controller registers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'hc;
    localparam int CMD_RD = 16;
    localparam int CMD_SA_LO = 17;
    localparam logic CTRL_RUN_RST = 1'b1;
endpackage

// >>> hw/xpc_sync.sv
// Two-flop synchroniser, one chain per bit
module xpc_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_r;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                meta_r <= 1'b0;
                q[i] <= 1'b0;
            end else begin
                meta_r <= d[i];
                q[i] <= meta_r;
            end
        end
    end
endmodule

// >>> verification/tb_crosspoint_switch_cmd_decoder.sv
// Self-checking bench: controller and switch device joined by the link
module tb_crosspoint_switch_cmd_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] strap;
    logic [95:0] switch_closed;
    logic [95:0] model;
    logic [31:0] rd;
    int num_errors;
    int n_checks;
    xpc_if link ();
    xpc_host u_xpc_host (.mclk(mclk), .rst(rst), .link(link),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    xpc_dev u_xpc_dev (.mclk(mclk), .rst(rst), .link(link),
        .address_strap_bit0(strap[0]), .address_strap_bit1(strap[1]),
        .address_strap_bit2(strap[2]), .switch_closed(switch_closed));
    xpc_link_sva u_xpc_link_sva (.mclk(mclk), .rst(rst), .scl(link.scl),
        .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
        .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe),
        .sda(link.sda), .rst_n(link.rst_n));
    task automatic chk(input string nm, input logic [95:0] e,
                       input logic [95:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request stands until the rising edge that sees waitrequest low
    task automatic av(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic cmd(input logic [2:0] sa, input logic r,
                       input logic [15:0] w);
        int n;
        n = 0;
        av(1'b1, xpc_pkg::REG_CMD, {12'h000, sa, r, w});
        do begin
            av(1'b0, xpc_pkg::REG_STAT, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 1000);
    endtask
    // Don't-care bits always carry a nonzero pattern
    task automatic sw(input logic [3:0] rc, input logic [2:0] col,
                      input logic v, input logic ld);
        cmd(strap, 1'b0, {v, rc, col, 7'h55, ld});
    endtask
    task automatic t_regs();
        chk("switches", 96'h0, switch_closed);
        av(1'b0, xpc_pkg::REG_CTRL, 32'h0000_0000);
        chk("ctrl", 96'h1, rd);
        av(1'b0, xpc_pkg::REG_CMD, 32'h0000_0000);
        chk("cmd", 96'h0, rd);
        av(1'b0, 4'h2, 32'h0000_0000);
        chk("unmapped", 96'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_rows();
        for (int i = 0; i < 12; i++) begin
            sw((i < 6) ? 4'(i) : 4'(i + 2), 3'(i % 8), 1'b1, 1'b1);
            model[i * 8 + i % 8] = 1'b1;
            chk("switches", model, switch_closed);
        end
        sw(4'h0, 3'h0, 1'b0, 1'b1);
        model[0] = 1'b0;
        chk("switches", model, switch_closed);
        $display("test rows done");
    endtask
    task automatic t_latched();
        sw(4'h2, 3'h6, 1'b1, 1'b0);
        sw(4'hb, 3'h2, 1'b1, 1'b0);
        chk("switches", model, switch_closed);
        sw(4'h4, 3'h5, 1'b1, 1'b1);
        model[22] = 1'b1;
        model[74] = 1'b1;
        model[37] = 1'b1;
        chk("switches", model, switch_closed);
        $display("test latched done");
    endtask
    task automatic t_refuse();
        logic [3:0] res [4] = '{4'h6, 4'h7, 4'he, 4'hf};
        // Dropped commands leave the nack flag alone, so they go first
        foreach (res[k]) begin
            cmd(strap, 1'b0, {1'b1, res[k], 3'h3, 8'h01});
            chk("status", 96'h4, rd[2:0]);
        end
        cmd(~strap, 1'b0, 16'h8701);
        chk("status", 96'h2, rd[2:0]);
        chk("switches", model, switch_closed);
        $display("test refuse done");
    endtask
    task automatic t_readback();
        sw(4'h2, 3'h6, 1'b1, 1'b1);
        cmd(strap, 1'b1, 16'h0000);
        chk("status", 96'h0, rd[2:0]);
        av(1'b0, xpc_pkg::REG_RDATA, 32'h0000_0000);
        chk("readback", {88'h0, model[16 +: 8]}, rd);
        $display("test readback done");
    endtask
    task automatic t_linkrst();
        av(1'b1, xpc_pkg::REG_CTRL, 32'h0000_0000);
        repeat (8) @(posedge mclk);
        model = 96'h0;
        chk("switches", model, switch_closed);
        cmd(strap, 1'b0, 16'h9901);
        chk("switches", model, switch_closed);
        av(1'b1, xpc_pkg::REG_CTRL, 32'h0000_0001);
        repeat (8) @(posedge mclk);
        sw(4'h1, 3'h3, 1'b1, 1'b1);
        model[11] = 1'b1;
        chk("switches", model, switch_closed);
        $display("test linkrst done");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        strap = 3'h5;
        model = 96'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (12) @(posedge mclk);
        t_regs();
        t_rows();
        t_latched();
        t_refuse();
        t_readback();
        t_linkrst();
        print_verdict();
    end
    // About five times the expected run length
    initial begin
        #(50 * 60000);
        num_errors++;
        $display("ERROR watchdog expired");
        print_verdict();
    end
endmodule

// >>> verification/xpc_link_sva.sv
// Protocol checks on the two-wire link between controller and device
module xpc_link_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic sda,
    input wire logic rst_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic scl_d_r;
    logic sda_d_r;
    logic [5:0] rises_r;
    // Link clock rises since the last start; a start restarts the count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            rises_r <= 6'h0;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
            if (scl && scl_d_r && sda_d_r && !sda) begin
                rises_r <= 6'h0;
            end else if (scl && !scl_d_r) begin
                rises_r <= rises_r + 6'h1;
            end
        end
    end
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    a_host_pull: assert property (m_sda_oe |-> !m_sda_o && !sda)
        else $error("host drive does not pull data low");
    a_ack_pull: assert property (s_sda_oe |-> !s_sda_o && !sda)
        else $error("device drive does not pull data low");
    a_dev_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("device data moved while link clock high");
    a_rst_hold: assert property (!scl |-> rst_n)
        else $error("device reset low inside a frame");
    a_scl_low_len: assert property ($fell(scl) |=> !scl [*4])
        else $error("link clock low phase too short");
    a_ack_slot: assert property (
        $rose(s_sda_oe) && rises_r < 6'h9 |-> rises_r == 6'h8)
        else $error("address acknowledge outside the ninth slot");
    a_stop_count: assert property (
        s_stop |-> rises_r == 6'h1c || rises_r == 6'ha)
        else $error("stop after wrong number of link clocks");
    a_start_quiet: assert property (s_start |-> !s_sda_oe)
        else $error("device pulls data at a start");
endmodule
